// file: inc/dies_pkg.sv
/*
  Package for the double image exposure sequencer: timing modes, states,
  timing constants at 25 MHz.
  Assumes a single 25 MHz clock.
*/
package dies_pkg;
  localparam int unsigned CLK_HZ           = 25000000;
  // shutter travel time, milliseconds
  localparam int unsigned SHUTTER_MS       = 8;
  localparam int unsigned SHUTTER_CYC      = (SHUTTER_MS * (CLK_HZ / 1000));
  // least exposure, microseconds
  localparam int unsigned EXP_MIN_US       = 1;
  localparam int unsigned EXP_MIN_CYC      = (EXP_MIN_US * (CLK_HZ / 1000000));
  // longest exposure 14.3 minutes, kept in tenths of a second to stay integral
  localparam longint unsigned EXP_MAX_DS   = 8580;
  localparam longint unsigned EXP_MAX_CYC  = (EXP_MAX_DS * (CLK_HZ / 10));
  localparam int unsigned EXP_W            = 35;
  // ready low window in single-shot mode, nanoseconds
  localparam int unsigned READY_LOW_NS     = 400;
  localparam int unsigned CLK_NS           = 40;
  localparam int unsigned READY_LOW_CYC    = ((READY_LOW_NS + CLK_NS - 1) / CLK_NS);
  // one sensor clean cycle, cycles
  localparam int unsigned CLEAN_CYC        = 16;
  localparam int unsigned CNT_W            = 35;
  localparam logic [1:0]  MODE_SINGLE      = 2'h0;
  localparam logic [1:0]  MODE_INTERNAL    = 2'h1;
  localparam logic [1:0]  MODE_EXTERNAL    = 2'h2;
  localparam logic [1:0]  MODE_GAPPED      = 2'h3;

  typedef enum logic [10:0] {
    S_IDLE     = 11'h001,
    S_OPEN     = 11'h002,
    S_CLEAN    = 11'h004,
    S_ARMED    = 11'h008,
    S_EXP1     = 11'h010,
    S_PARK     = 11'h020,
    S_EXP2     = 11'h040,
    S_CLOSE    = 11'h080,
    S_READ1    = 11'h100,
    S_READ2    = 11'h200,
    S_GAP      = 11'h400
  } dies_state_t;

  typedef struct packed {
    dies_state_t       st;
    logic [CNT_W-1:0]  cnt;
    logic              trig_q;
    logic              armed2;
    logic              ready_n;
    logic              shutter;
    logic              clean;
    logic              integrate;
    logic              park;
    logic              readout;
    logic              frame;
    logic              busy;
  } dies_regs_t;
endpackage : dies_pkg

// file: src/dies_top.sv
/*
  Exposure and shutter sequencer for a dual-image interline camera.
  Assumes synchronous trigger input, a readout engine that acknowledges
  each frame with a done pulse, and a 25 MHz clock.
*/
`timescale 1ns/10ps
// Functional notes
// R1 - single-shot: one image, programmed exposure, 14.3 min max
// R2 - exposure waits for shutter fully open
// R3 - allow 8 ms shutter open and close
// R4 - readout waits for shutter fully closed
// R5 - ready low only after open and cleans
// R6 - ready rises exactly when first exposure starts
// R7 - single-shot ready low lasts 400 to 600 ns
// R8 - shutter hold-open option skips shutter waits
// R9 - internal pair: ready low until trigger edge
// R10 - clean continuously while waiting for trigger
// R11 - triggers before ready low are ignored
// R12 - first exposure then park image in storage
// R13 - internal pair: second exposure, then close shutter
// R14 - read first image before second
// R15 - external pair: trigger width sets first exposure
// R16 - gapped pair: two triggers, equal exposures
// R17 - four selectable timing modes
// R18 - capture only on first trigger after ready
// R19 - ready loopback only valid in internal mode
// R20 - ready high during exposure, shutter, readout, init
module dies_top
  import dies_pkg::*;
(
  input  wire logic                      I_CLOCK,
  input  wire logic                      I_RST_N,
  input  wire logic                      I_START,
  input  wire logic [1:0]                I_MODE,
  input  wire logic                      I_SHUTTER_HOLD_OPEN,
  input  wire logic [dies_pkg::EXP_W-1:0] I_EXPOSURE_CYC,
  input  wire logic                      I_TRIGGER,
  input  wire logic                      I_READOUT_DONE,
  output logic                           O_READY_N,
  output logic                           O_SHUTTER_OPEN,
  output logic                           O_CLEAN,
  output logic                           O_INTEGRATE,
  output logic                           O_PARK,
  output logic                           O_READOUT,
  output logic                           O_FRAME,
  output logic                           O_BUSY
);
  import dies_pkg::*;

  dies_regs_t q, d;
  logic [EXP_W-1:0] exp_cyc;
  logic             trig_rise;
  logic             trig_fall;

  // mode decoding is shared by several states
  function automatic logic is_single(input logic [1:0] m);
    return (m == MODE_SINGLE);
  endfunction : is_single

  function automatic logic is_pair(input logic [1:0] m);
    return (m != MODE_SINGLE);
  endfunction : is_pair

  function automatic logic is_external(input logic [1:0] m);
    return (m == MODE_EXTERNAL);
  endfunction : is_external

  function automatic logic is_gapped(input logic [1:0] m);
    return (m == MODE_GAPPED);
  endfunction : is_gapped

  // edges are taken against the registered copy of the trigger, which is
  // refreshed every cycle, so a level held across ready falling gives no edge
  function automatic logic rise_of(input logic now_v, input logic last_v);
    return now_v & ~last_v;
  endfunction : rise_of

  function automatic logic fall_of(input logic now_v, input logic last_v);
    return ~now_v & last_v;
  endfunction : fall_of

  // the counter reaches zero on the last exposure cycle, so load one less
  function automatic logic [CNT_W-1:0] exposure_load(input logic [EXP_W-1:0] e);
    logic [CNT_W-1:0] r;
    r = CNT_W'(e) - CNT_W'(1);
    return r;
  endfunction : exposure_load

  // a shutter held open never travels, so no close wait is counted
  function automatic logic [CNT_W-1:0] close_load(input logic hold);
    logic [CNT_W-1:0] r;
    r = CNT_W'(SHUTTER_CYC); // R3
    if (hold) begin
      r = '0; // R8
    end
    return r;
  endfunction : close_load

  // out-of-range programming is clamped rather than refused, so a bad value
  // still gives a bounded acquisition
  function automatic logic [EXP_W-1:0] clamp_exposure(input logic [EXP_W-1:0] e);
    logic [EXP_W-1:0] r;
    r = e;
    if (e < EXP_W'(EXP_MIN_CYC)) begin
      r = EXP_W'(EXP_MIN_CYC); // R12
    end else if (e > EXP_W'(EXP_MAX_CYC)) begin
      r = EXP_W'(EXP_MAX_CYC); // R1
    end
    return r;
  endfunction : clamp_exposure

  assign exp_cyc   = clamp_exposure(I_EXPOSURE_CYC);
  assign trig_rise = rise_of(I_TRIGGER, q.trig_q);
  assign trig_fall = fall_of(I_TRIGGER, q.trig_q);

  // next state starts as a copy of the held state; each state changes only
  // the fields it owns, so every output keeps its level between states
  always_comb begin
    d        = q;
    d.trig_q = I_TRIGGER;
    // the counter stops at zero so any state may test it on any cycle
    if (q.cnt == '0) begin
      d.cnt = '0;
    end else begin
      d.cnt = q.cnt - CNT_W'(1);
    end
    case (q.st)
      S_IDLE: begin
        d.ready_n   = 1'b1; // R20
        d.integrate = 1'b0;
        d.readout   = 1'b0;
        d.busy      = 1'b0;
        d.shutter   = I_SHUTTER_HOLD_OPEN;

        // start is looked at only here, so a start while busy is refused
        if (I_START) begin // R17
          d.busy    = 1'b1;
          d.armed2  = 1'b0;
          d.shutter = 1'b1;
          if (I_SHUTTER_HOLD_OPEN) begin
            // no shutter travel to wait for
            d.st  = S_CLEAN; // R8
            d.cnt = CNT_W'(CLEAN_CYC);
          end else begin
            d.st  = S_OPEN;
            d.cnt = CNT_W'(SHUTTER_CYC); // R3
          end
        end
      end

      S_OPEN: begin
        // the shutter drive rose on the start edge; wait out its full travel
        if (q.cnt == '0) begin // R2
          d.st    = S_CLEAN;
          d.cnt   = CNT_W'(CLEAN_CYC);
          d.clean = 1'b1;
        end
      end

      S_CLEAN: begin
        // a whole clean cycle runs before ready may fall
        d.clean = 1'b1;
        if (q.cnt == '0) begin
          d.st      = S_ARMED;
          d.ready_n = 1'b0; // R5
          if (is_single(I_MODE)) begin
            // single shot holds ready low for a fixed window, not for a trigger
            d.cnt = CNT_W'(READY_LOW_CYC); // R7
          end else begin
            d.cnt = CNT_W'(CLEAN_CYC);
          end
        end
      end

      S_ARMED: begin
        d.clean = 1'b1; // R10
        if (q.cnt == '0 && is_pair(I_MODE)) begin
          // restart the clean cycle so cleaning runs until the trigger
          d.cnt = CNT_W'(CLEAN_CYC);
        end

        // the edge detector saw the trigger before ready fell, so a held-high
        // trigger gives no edge here and is ignored
        if ((is_single(I_MODE) && q.cnt == '0) ||
            (is_pair(I_MODE) && trig_rise)) begin // R9 R11 R18 R7
          d.ready_n   = 1'b1; // R6
          d.clean     = 1'b0;
          d.integrate = 1'b1;
          d.st        = S_EXP1;
          d.cnt       = exposure_load(exp_cyc); // R12
        end
      end

      S_EXP1: begin
        // external pair ends the first image on the trigger's falling edge
        if ((is_external(I_MODE) && trig_fall) ||
            (!is_external(I_MODE) && q.cnt == '0)) begin // R15
          if (is_single(I_MODE)) begin
            // single shot has no second image; close straight away
            d.integrate = 1'b0; // R1
            d.st        = S_CLOSE;
            d.cnt       = close_load(I_SHUTTER_HOLD_OPEN);
            d.shutter   = I_SHUTTER_HOLD_OPEN;
          end else begin
            d.park = 1'b1; // R12
            d.st   = S_PARK;
          end
        end
      end

      S_PARK: begin
        d.park = 1'b0;
        if (is_gapped(I_MODE) && !q.armed2) begin
          // photodiodes are dumped between images, so nothing integrates in the gap
          d.integrate = 1'b0; // R16
          d.armed2    = 1'b1;
          d.ready_n   = 1'b0;
          d.st        = S_GAP;
        end else begin
          // the other pairs go straight on to the second image
          d.st  = S_EXP2; // R13
          d.cnt = exposure_load(exp_cyc);
        end
      end

      S_GAP: begin
        // a trigger still high from the first image gives no edge here
        if (trig_rise) begin // R16
          d.ready_n   = 1'b1;
          d.integrate = 1'b1;
          d.st        = S_EXP2;
          d.cnt       = exposure_load(exp_cyc);
        end
      end

      S_EXP2: begin
        // the second exposure lasts the programmed time, as the first does in internal and gapped pair
        if (q.cnt == '0) begin // R13
          d.st      = S_CLOSE;
          d.shutter = I_SHUTTER_HOLD_OPEN;
          d.cnt     = close_load(I_SHUTTER_HOLD_OPEN); // R3 R8
        end
      end

      S_CLOSE: begin
        // second image keeps integrating until the shutter is shut
        if (q.cnt == '0) begin // R4
          d.integrate = 1'b0;
          d.readout   = 1'b1;
          d.frame     = 1'b0; // R14
          d.st        = S_READ1;
        end
      end

      S_READ1: begin
        // the parked first image leaves the sensor first
        if (I_READOUT_DONE) begin
          if (is_single(I_MODE)) begin
            d.readout = 1'b0;
            d.st      = S_IDLE;
          end else begin
            d.frame = 1'b1; // R14
            d.st    = S_READ2;
          end
        end
      end

      S_READ2: begin
        // busy drops on the idle cycle that follows
        if (I_READOUT_DONE) begin
          d.readout = 1'b0;
          d.frame   = 1'b0;
          d.st      = S_IDLE;
        end
      end

      default: begin
        // an illegal code falls back to idle with ready high
        d         = '0;
        d.st      = S_IDLE;
        d.ready_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      q         <= '0;
      q.st      <= S_IDLE;
      q.ready_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign O_READY_N      = q.ready_n;
  assign O_SHUTTER_OPEN = q.shutter;
  assign O_CLEAN        = q.clean;
  assign O_INTEGRATE    = q.integrate;
  assign O_PARK         = q.park;
  assign O_READOUT      = q.readout;
  assign O_FRAME        = q.frame;
  assign O_BUSY         = q.busy;
endmodule : dies_top

// file: testbench/dies_top_properties.sv
/*
  Port-level checker for the exposure sequencer, bound into dies_top.
  Assumes one clock domain and the async active-low reset of the top.
*/
`timescale 1ns/10ps
module dies_top_properties (
  input wire logic       I_CLOCK,
  input wire logic       I_RST_N,
  input wire logic [1:0] I_MODE,
  input wire logic       O_READY_N,
  input wire logic       O_SHUTTER_OPEN,
  input wire logic       O_CLEAN,
  input wire logic       O_INTEGRATE,
  input wire logic       O_PARK,
  input wire logic       O_READOUT,
  input wire logic       O_FRAME,
  input wire logic       O_BUSY
);
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);
  property p_ready_after_clean; $fell(O_READY_N) |-> O_BUSY && (O_CLEAN || $past(O_PARK)); endproperty
  a_ready_after_clean: assert property (p_ready_after_clean) else $error("ready fell without clean");
  property p_rise_marks_exp; $rose(O_READY_N) |-> O_INTEGRATE; endproperty
  a_rise_marks_exp: assert property (p_rise_marks_exp) else $error("ready rose without exposure");
  property p_single_low; $fell(O_READY_N) && I_MODE == 2'h0 |-> (!O_READY_N)[*8] ##[1:7] O_READY_N; endproperty
  a_single_low: assert property (p_single_low) else $error("single ready low width wrong");
  property p_high_in_exp; O_INTEGRATE || O_READOUT |-> O_READY_N; endproperty
  a_high_in_exp: assert property (p_high_in_exp) else $error("ready low during exposure");
  property p_park_pulse; O_PARK |=> !O_PARK; endproperty
  a_park_pulse: assert property (p_park_pulse) else $error("park longer than one cycle");
  property p_park_mode; O_PARK |-> I_MODE != 2'h0; endproperty
  a_park_mode: assert property (p_park_mode) else $error("park in single mode");
  property p_read_after; O_READOUT |-> !O_INTEGRATE && O_BUSY; endproperty
  a_read_after: assert property (p_read_after) else $error("readout during exposure");
  property p_frame_order; $rose(O_FRAME) |-> O_READOUT && I_MODE != 2'h0; endproperty
  a_frame_order: assert property (p_frame_order) else $error("second frame out of order");
  property p_open_first; O_INTEGRATE |-> O_SHUTTER_OPEN; endproperty
  a_open_first: assert property (p_open_first) else $error("exposure with shutter shut");
  c_park: cover property (O_PARK);
  c_frame: cover property ($rose(O_FRAME));
  c_ready: cover property ($fell(O_READY_N));
endmodule : dies_top_properties

bind dies_top dies_top_properties i_props (.*);

// file: testbench/dies_trig_src.sv
/*
  External trigger source: one pulse of given width per fire request.
  Assumes requests arrive at the falling edge of the clock.
*/
`timescale 1ns/10ps
module dies_trig_src (
  input  wire logic       i_clk,
  input  wire logic       i_fire,
  input  wire logic [7:0] i_width,
  output logic            o_trig
);
  int         n     = 0;
  logic       req   = 1'b0;
  logic [7:0] req_w = 8'h00;
  // requests are taken on the rising edge so they cannot race the bench,
  // which changes them on the falling edge
  always @(posedge i_clk) begin
    req   <= i_fire;
    req_w <= i_width;
  end
  // fires regardless of ready, so early pulses reach the device too
  always @(negedge i_clk) begin
    if (req) n = req_w;
    o_trig <= (n > 0);
    if (n > 0) n--;
  end
endmodule : dies_trig_src

// file: testbench/double_image_exposure_sequencer_test.sv
/*
  Self-checking bench: runs all four timing modes with shutter held open.
  Assumes dies_top, its checker and the trigger source model.
*/
`timescale 1ns/10ps
module double_image_exposure_sequencer_test;
  import dies_pkg::*;
  logic clk = 0, rst_n = 0, start = 0, done = 0, fire = 0, trig;
  logic [1:0] mode = 0;
  logic [7:0] width = 0;
  logic [EXP_W-1:0] expo = 25;
  logic rdy_n, shut, cln, integ, park, rd, frame, busy;
  int miscompares = 0, checks_done = 0;
  logic [31:0] seed = 32'h04a0d15e;
  always #20 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  dies_top i_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_START(start), .I_MODE(mode),
    .I_SHUTTER_HOLD_OPEN(1'b1), .I_EXPOSURE_CYC(expo), .I_TRIGGER(trig), .I_READOUT_DONE(done),
    .O_READY_N(rdy_n), .O_SHUTTER_OPEN(shut), .O_CLEAN(cln), .O_INTEGRATE(integ), .O_PARK(park),
    .O_READOUT(rd), .O_FRAME(frame), .O_BUSY(busy));
  dies_trig_src i_src (.i_clk(clk), .i_fire(fire), .i_width(width), .o_trig(trig));
  task automatic check(input logic [35:0] seen, input logic [35:0] expv);
    checks_done++;
    if (seen !== expv) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check
  task automatic pulse(input logic [7:0] w);
    fire = 1;
    width = w;
    @(negedge clk) fire = 0;
  endtask : pulse
  task automatic run(input logic [1:0] m);
    int n, e, fr;
    seed = lfsr_next(seed);
    e = 25 + seed[5:0];
    fr = (m == 2'h0) ? 1 : 2;
    mode = m;
    expo = e[EXP_W-1:0];
    start = 1;
    @(negedge clk) start = 0;
    pulse(8'h02);
    for (n = 0; n < 300 && rdy_n !== 1'b0; n++) @(negedge clk);
    check({cln, shut}, 2'h3);
    if (m == 2'h0) begin
      for (n = 0; n < 50 && rdy_n === 1'b0; n++) @(negedge clk);
      check(n >= 10 && n <= 15, 1'b1);
      check(integ, 1'b1);
    end else begin
      repeat (20) @(negedge clk);
      check(rdy_n, 1'b0);
      pulse((m == 2'h2) ? 8'h28 : 8'h03);
      for (n = 1; n < 300 && park !== 1'b1; n++) @(negedge clk);
      check(n + 4 >= ((m == 2'h2) ? 40 : e) && n <= ((m == 2'h2) ? 40 : e) + 4, 1'b1);
      if (m == 2'h3) begin
        for (n = 0; n < 300 && rdy_n !== 1'b0; n++) @(negedge clk);
        check(rdy_n, 1'b0);
        pulse(8'h03);
      end
    end
    for (n = 0; n < 300 && rd !== 1'b1; n++) @(negedge clk);
    check(n + 4 >= e && n <= e + 4, 1'b1);
    for (int k = 0; k < fr; k++) begin
      check({rd, frame}, {1'b1, k[0]});
      done = 1;
      @(negedge clk) done = 0;
      @(negedge clk);
    end
    check(busy, 1'b0);
  endtask : run
  task automatic stop_test;
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    for (int m = 0; m < 4; m++) run(m[1:0]);
    // second pass with fresh exposure values catches stale state
    for (int m = 3; m >= 0; m--) run(m[1:0]);
    stop_test();
  end
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
endmodule : double_image_exposure_sequencer_test
